//--- common/smr_map.svh
/*
 * register offsets, field positions, masks and reset values of the
 * programming-port register bank.
 * assumes: included by bare name from the package and the design file.
 */
`ifndef SMR_MAP_SVH
`define SMR_MAP_SVH

// ----------------------------------------------------------------------
// address decode
// ----------------------------------------------------------------------
`define SMR_ADDR_W 12
`define SMR_SEC_LIMIT 12'h040

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define SMR_OFS_CR0 12'h000
`define SMR_OFS_CR0_DONE 12'h004
`define SMR_OFS_IRQ_EN 12'h008
`define SMR_OFS_IRQ_DONE 12'h00C
`define SMR_OFS_GBPA 12'h010
`define SMR_OFS_INIT 12'h014
`define SMR_OFS_GERR 12'h018
`define SMR_OFS_GERR_ACK 12'h01C
`define SMR_OFS_STRTAB_LO 12'h020
`define SMR_OFS_STRTAB_HI 12'h024
`define SMR_OFS_ERR_TCU 12'h040
`define SMR_OFS_ERR_TBU 12'h044
`define SMR_OFS_IDR_FIFTH 12'h050
`define SMR_OFS_GSTATUS 12'h054
`define SMR_OFS_XLATE_OP_LO 12'h060
`define SMR_OFS_XLATE_OP_HI 12'h07C
`define SMR_OFS_PMU_CNT_LO 12'h080
`define SMR_OFS_PMU_CNT_HI 12'h084
`define SMR_OFS_PMU_CTRL 12'h088
`define SMR_OFS_PMU_IRQ_LO 12'h08C
`define SMR_OFS_PMU_IRQ_HI 12'h094

// ----------------------------------------------------------------------
// implemented bits of each register
// ----------------------------------------------------------------------
`define SMR_MASK_CR0 32'h0000_001F
`define SMR_MASK_IRQ_EN 32'h0000_0007
`define SMR_MASK_GBPA 32'h001F_FFFF
`define SMR_MASK_GERR 32'h0000_0003
`define SMR_MASK_PMU_CTRL 32'h0000_0001

// ----------------------------------------------------------------------
// error record status fields
// ----------------------------------------------------------------------
`define SMR_ERR_V 32'h4000_0000
`define SMR_ERR_UE 32'h2000_0000
`define SMR_ERR_OF 32'h0800_0000
`define SMR_ERR_CE 32'h0300_0000
`define SMR_ERR_CE_REC 32'h0200_0000
`define SMR_ERR_DE 32'h0080_0000
`define SMR_ERR_STICKY 32'h6B80_0000

// ----------------------------------------------------------------------
// reset value and answers
// ----------------------------------------------------------------------
`define SMR_RESET_WORD 32'h0000_0000
`define SMR_RESP_OKAY 2'b00

`endif

//--- common/smr_pkg.sv
/*
 * types of the programming-port register bank.
 * assumes: smr_map.svh on the include path.
 */
`include "smr_map.svh"

package smr_pkg;

   // ----------------------------------------------------------------------
   // whole state of the register bank
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic aw_held;
      logic w_held;
      logic [`SMR_ADDR_W-1:0] awaddr;
      logic aw_ns;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic rvalid;
      logic [31:0] rdata;
      logic [31:0] cr0;
      logic [31:0] cr0_done;
      logic [31:0] irq_en;
      logic [31:0] irq_done;
      logic [31:0] gbpa;
      logic init_busy;
      logic [31:0] gerr;
      logic [31:0] gerr_ack;
      logic [63:0] strtab;
      logic [1:0][31:0] err_rec;
      logic pmu_en;
      logic [63:0] pmu_cnt;
   } smr_state_t;

endpackage

//--- tb/smr_inval_model.sv
/* behavioural cache-invalidation engine facing the register bank.
   assumes: same clock and reset as the bank. */
`timescale 1ns/1ps
module smr_inval_model #(parameter int DELAY = 3) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic req,
   output logic done
);
   int cnt_ff;

   // one-cycle done after DELAY cycles of request
   always_ff @(posedge aclk)
      if (!aresetn || !req || done)
      begin
         cnt_ff <= 0;
         done <= 1'b0;
      end
      else
      begin
         cnt_ff <= cnt_ff + 1;
         done <= (cnt_ff == DELAY - 1);
      end
endmodule

//--- tb/smr_programming_port_assertions.sv
/* concurrent checks on the ports of the programming-port register bank.
   assumes: bound into smr_programming_port_regs, one clock aclk, sync aresetn. */
`timescale 1ns/1ps
`include "smr_map.svh"
module smr_programming_port_assertions (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`SMR_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic [`SMR_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] secure_global_control0,
   input wire logic [31:0] secure_interrupt_enables,
   input wire logic [31:0] secure_global_bypass_attributes,
   input wire logic secure_cache_invalidate_req,
   input wire logic secure_cache_invalidate_done
);
   // --------------------------------------------------------------------
   // one clock domain for every check
   // --------------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // handshakes, answers and their timing
   a_b_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("late write answer");
   a_b_okay: assert property (
      s_axi_bvalid |-> s_axi_bresp == `SMR_RESP_OKAY)
      else $error("write answer not okay");
   a_r_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
      && s_axi_rresp == `SMR_RESP_OKAY) else $error("bad read answer");
   // filtered and missing locations
   a_ns_read_zero: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_arprot[1]
      && s_axi_araddr < `SMR_SEC_LIMIT |=> s_axi_rdata == 32'h0000_0000)
      else $error("non-secure read saw data");
   a_ns_write_kept: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_awprot[1] && s_axi_awaddr < `SMR_SEC_LIMIT
      |-> ##2 $stable(secure_global_control0)
      && $stable(secure_global_bypass_attributes))
      else $error("non-secure write changed state");
   a_unimpl_zero: assert property (
      s_axi_arvalid && s_axi_arready && (s_axi_araddr == `SMR_OFS_IDR_FIFTH
      || s_axi_araddr == `SMR_OFS_GSTATUS
      || (s_axi_araddr >= `SMR_OFS_XLATE_OP_LO
      && s_axi_araddr <= `SMR_OFS_XLATE_OP_HI))
      |=> s_axi_rdata == 32'h0000_0000) else $error("missing reg read data");
   // reserved bits, reset and invalidate hand-off
   a_reserved_zero: assert property (
      secure_global_control0[31:5] == 0 && secure_interrupt_enables[31:3] == 0
      && secure_global_bypass_attributes[31:21] == 0)
      else $error("reserved bit set");
   a_reset_zero: assert property (
      $rose(aresetn) |-> secure_global_control0 == 0
      && secure_interrupt_enables == 0 && !secure_cache_invalidate_req
      && secure_global_bypass_attributes == 0) else $error("bad reset value");
   a_inval_drop: assert property (
      $fell(secure_cache_invalidate_req) && $past(aresetn)
      |-> $past(secure_cache_invalidate_done))
      else $error("invalidate dropped early");
endmodule

bind smr_programming_port_regs smr_programming_port_assertions chk_u (.*);

//--- tb/tb_top.sv
/* self-checking bench of the programming-port register bank.
   assumes: smr_pkg, the bank, its checker and the engine model. */
`timescale 1ns/1ps
`include "smr_map.svh"
module tb_top;
   logic aclk, aresetn;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [31:0] secure_global_control0, secure_interrupt_enables;
   logic [31:0] secure_global_bypass_attributes;
   logic [63:0] secure_stream_table_base;
   logic secure_cache_invalidate_req, secure_cache_invalidate_done;
   logic [1:0] secure_global_error_event, error_record_event;
   logic [1:0] error_record_uncorrected;
   logic performance_counter_event;
   int fail_count, comparisons;

   smr_programming_port_regs dut_u (.*);
   smr_inval_model #(.DELAY(6)) inv_u (.aclk(aclk), .aresetn(aresetn),
      .req(secure_cache_invalidate_req), .done(secure_cache_invalidate_done));

   // --------------------------------------------------------------------
   // bus and compare helpers
   // --------------------------------------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic ns, input logic [1:0] ev);
      logic aw_p, w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      s_axi_awaddr <= a;
      s_axi_awprot <= {1'b0, ns, 1'b0};
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         aw_p = aw_p && (s_axi_awready !== 1'b1);
         w_p = w_p && (s_axi_wready !== 1'b1);
         s_axi_awvalid <= aw_p;
         s_axi_wvalid <= w_p;
      end
      while (aw_p || w_p);
      // optional record event lands on the edge that applies the write
      error_record_event <= ev;
      @(posedge aclk);
      error_record_event <= 2'b00;
      do
         @(posedge aclk);
      while (s_axi_bvalid !== 1'b1);
   endtask

   task automatic rdc(input logic [11:0] a, input logic ns,
      input logic [31:0] exp);
      s_axi_araddr <= a;
      s_axi_arprot <= {1'b0, ns, 1'b0};
      s_axi_arvalid <= 1'b1;
      do
         @(posedge aclk);
      while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do
         @(posedge aclk);
      while (s_axi_rvalid !== 1'b1);
      chk(s_axi_rdata, exp);
   endtask

   task automatic pulse(input logic [1:0] g, input logic [1:0] e,
      input logic [1:0] u);
      error_record_uncorrected <= u;
      secure_global_error_event <= g;
      error_record_event <= e;
      @(posedge aclk);
      secure_global_error_event <= 2'b00;
      error_record_event <= 2'b00;
      @(posedge aclk);
   endtask

   // --------------------------------------------------------------------
   // scenarios
   // --------------------------------------------------------------------
   task automatic t_masks();
      rdc(`SMR_OFS_CR0, 1'b0, 32'h0000_0000);
      rdc(`SMR_OFS_ERR_TCU, 1'b0, 32'h0000_0000);
      wr(`SMR_OFS_CR0, 32'hffff_ffff, 1'b0, 2'b00);
      wr(`SMR_OFS_IRQ_EN, 32'hffff_ffff, 1'b0, 2'b00);
      wr(`SMR_OFS_GBPA, 32'hffff_ffff, 1'b0, 2'b00);
      rdc(`SMR_OFS_CR0, 1'b0, `SMR_MASK_CR0);
      rdc(`SMR_OFS_CR0_DONE, 1'b0, `SMR_MASK_CR0);
      rdc(`SMR_OFS_IRQ_DONE, 1'b0, `SMR_MASK_IRQ_EN);
      rdc(`SMR_OFS_GBPA, 1'b0, `SMR_MASK_GBPA);
      chk(secure_global_bypass_attributes, `SMR_MASK_GBPA);
      // software looks only at the defined enable bits
      chk(secure_interrupt_enables & `SMR_MASK_IRQ_EN,
         `SMR_MASK_IRQ_EN);
   endtask

   task automatic t_secure_wide();
      wr(`SMR_OFS_CR0, 32'h0000_0003, 1'b1, 2'b00);
      rdc(`SMR_OFS_CR0, 1'b1, 32'h0000_0000);
      rdc(`SMR_OFS_CR0, 1'b0, `SMR_MASK_CR0);
      chk(secure_global_control0, `SMR_MASK_CR0);
      wr(`SMR_OFS_STRTAB_LO, 32'h1234_5678, 1'b0, 2'b00);
      wr(`SMR_OFS_STRTAB_HI, 32'h9abc_def0, 1'b0, 2'b00);
      wr(`SMR_OFS_STRTAB_LO, 32'h0000_1111, 1'b0, 2'b00);
      rdc(`SMR_OFS_STRTAB_HI, 1'b0, 32'h9abc_def0);
      chk(secure_stream_table_base, 64'h9abc_def0_0000_1111);
   endtask

   task automatic t_unused();
      logic [11:0] ua [8];
      ua = '{`SMR_OFS_IDR_FIFTH, `SMR_OFS_GSTATUS, `SMR_OFS_XLATE_OP_LO,
         `SMR_OFS_XLATE_OP_HI, `SMR_OFS_PMU_IRQ_LO, `SMR_OFS_PMU_IRQ_HI,
         12'h028, 12'h0f0};
      foreach (ua[i])
      begin
         wr(ua[i], 32'hffff_ffff, 1'b0, 2'b00);
         rdc(ua[i], 1'b0, 32'h0000_0000);
      end
      rdc(`SMR_OFS_GBPA, 1'b0, `SMR_MASK_GBPA);
   endtask

   task automatic t_counter();
      wr(`SMR_OFS_PMU_CTRL, 32'h0000_0001, 1'b0, 2'b00);
      performance_counter_event <= 1'b1;
      repeat (3) @(posedge aclk);
      performance_counter_event <= 1'b0;
      rdc(`SMR_OFS_PMU_CNT_LO, 1'b0, 32'h0000_0003);
      wr(`SMR_OFS_PMU_CNT_HI, 32'h0000_0005, 1'b0, 2'b00);
      rdc(`SMR_OFS_PMU_CNT_HI, 1'b0, 32'h0000_0005);
      // a disabled counter ignores its event
      wr(`SMR_OFS_PMU_CTRL, 32'h0000_0000, 1'b0, 2'b00);
      performance_counter_event <= 1'b1;
      @(posedge aclk);
      performance_counter_event <= 1'b0;
      rdc(`SMR_OFS_PMU_CNT_LO, 1'b0, 32'h0000_0003);
   endtask

   task automatic t_errrec();
      pulse(2'b00, 2'b01, 2'b01);
      pulse(2'b00, 2'b01, 2'b01);
      rdc(`SMR_OFS_ERR_TCU, 1'b0, 32'h6800_0000);
      wr(`SMR_OFS_ERR_TCU, `SMR_ERR_V | `SMR_ERR_UE, 1'b0, 2'b00);
      rdc(`SMR_OFS_ERR_TCU, 1'b0, 32'h6800_0000);
      error_record_uncorrected <= 2'b00;
      wr(`SMR_OFS_ERR_TCU, `SMR_ERR_STICKY, 1'b0, 2'b01);
      rdc(`SMR_OFS_ERR_TCU, 1'b0, 32'h4200_0000);
      wr(`SMR_OFS_ERR_TCU, `SMR_ERR_V | `SMR_ERR_CE_REC, 1'b0, 2'b00);
      rdc(`SMR_OFS_ERR_TCU, 1'b0, 32'h4200_0000);
      wr(`SMR_OFS_ERR_TCU, `SMR_ERR_V | `SMR_ERR_CE, 1'b0, 2'b00);
      rdc(`SMR_OFS_ERR_TCU, 1'b0, 32'h0000_0000);
      pulse(2'b00, 2'b10, 2'b10);
      rdc(`SMR_OFS_ERR_TBU, 1'b0, 32'h6000_0000);
      wr(`SMR_OFS_ERR_TBU, `SMR_ERR_STICKY, 1'b0, 2'b00);
      rdc(`SMR_OFS_ERR_TBU, 1'b0, 32'h0000_0000);
   endtask

   task automatic t_gerr_init();
      pulse(2'b01, 2'b00, 2'b00);
      rdc(`SMR_OFS_GERR, 1'b0, 32'h0000_0001);
      wr(`SMR_OFS_GERR_ACK, 32'h0000_0001, 1'b0, 2'b00);
      rdc(`SMR_OFS_GERR_ACK, 1'b0, 32'h0000_0001);
      pulse(2'b01, 2'b00, 2'b00);
      rdc(`SMR_OFS_GERR, 1'b0, 32'h0000_0000);
      wr(`SMR_OFS_INIT, 32'h0000_0001, 1'b0, 2'b00);
      rdc(`SMR_OFS_INIT, 1'b0, 32'h0000_0001);
      repeat (10) @(posedge aclk);
      chk(secure_cache_invalidate_req, 64'h0);
      rdc(`SMR_OFS_INIT, 1'b0, 32'h0000_0000);
   endtask

   task automatic close_out();
      if (fail_count == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // --------------------------------------------------------------------
   // clock, watchdog and main sequence
   // --------------------------------------------------------------------
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   initial
   begin
      repeat (5000) @(posedge aclk);
      fail_count++;
      close_out();
   end

   initial
   begin
      fail_count = 0;
      comparisons = 0;
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_wstrb} = '0;
      {s_axi_wdata, secure_global_error_event, error_record_event} = '0;
      {error_record_uncorrected, performance_counter_event} = '0;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_masks();
      t_secure_wide();
      t_unused();
      t_counter();
      t_errrec();
      t_gerr_init();
      close_out();
   end
endmodule

//--- verilog/smr_programming_port_regs.sv
/*
 * register bank of the translation control unit's programming port,
 * an axi4-lite slave with secure filtering, error records and a
 * performance counter.
 * assumes: one clock aclk, synchronous active-low aresetn, all event
 * inputs come from logic on aclk.
 */
`timescale 1ns/1ps
`include "smr_map.svh"

// Notes on behaviour
// - only offset bits select a register
// - unused locations read zero, ignore writes
// - all bits reset to zero
// - reserved bits read zero, ignore writes
// - registers reachable only through this port
// - 64-bit registers accessed as 32-bit halves
// - non-secure access to secure registers RAZ/WI
// - unimplemented id, status, translation-op read zero
// - counter group present except interrupt config
// - error record fields cleared by writing ones
// - partial clear of set fields is discarded
// - clear plus new error records as empty
// - control0 update done reports applied value
// - interrupt enable update done reports completion
// - init control invalidates all secure caching
// - bypass attributes drive secure untranslated traffic
// - error ack register paired with error status
module smr_programming_port_regs (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`SMR_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`SMR_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] secure_global_control0,
   output logic [31:0] secure_interrupt_enables,
   output logic [31:0] secure_global_bypass_attributes,
   output logic [63:0] secure_stream_table_base,
   output logic secure_cache_invalidate_req,
   input wire logic secure_cache_invalidate_done,
   input wire logic [1:0] secure_global_error_event,
   input wire logic [1:0] error_record_event,
   input wire logic [1:0] error_record_uncorrected,
   input wire logic performance_counter_event
);
   import smr_pkg::*;

   // ----------------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------------

   // merge write data into a word under the byte strobes
   function automatic logic [31:0] strb_merge(
      input logic [31:0] old_word,
      input logic [31:0] new_word,
      input logic [3:0] strb
   );
      logic [31:0] res;
      res = old_word;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            res[i*8 +: 8] = new_word[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // locations of registers that are not built
   function automatic logic is_unimpl(input logic [`SMR_ADDR_W-1:0] a);
      return (a[11:2] == `SMR_OFS_IDR_FIFTH >> 2)
         || (a[11:2] == `SMR_OFS_GSTATUS >> 2)
         || (a >= `SMR_OFS_XLATE_OP_LO && a <= `SMR_OFS_XLATE_OP_HI)
         || (a >= `SMR_OFS_PMU_IRQ_LO && a <= `SMR_OFS_PMU_IRQ_HI);
   endfunction

   // non-secure access into the secure-only window
   function automatic logic is_blocked(
      input logic [`SMR_ADDR_W-1:0] a,
      input logic ns
   );
      return ns && (a < `SMR_SEC_LIMIT);
   endfunction

   // one error record: write-one-to-clear with all-or-nothing clearing
   function automatic logic [31:0] err_update(
      input logic [31:0] old_rec,
      input logic wr,
      input logic [31:0] wd,
      input logic ev,
      input logic ev_ue
   );
      logic [31:0] need;
      logic [31:0] rec;
      logic clr_ok;
      need = old_rec & `SMR_ERR_STICKY;
      // a set corrected field needs both bits written
      if ((old_rec & `SMR_ERR_CE) != 32'h0000_0000)
      begin
         need = need | `SMR_ERR_CE;
      end
      clr_ok = wr && ((wd & need) == need);
      rec = old_rec;
      if (clr_ok)
      begin
         rec = old_rec & ~(wd & `SMR_ERR_STICKY);
      end
      if (ev)
      begin
         // a cleared record takes the new error as if it were empty
         if ((rec & `SMR_ERR_V) == 32'h0000_0000)
         begin
            rec = `SMR_ERR_V
               | (ev_ue ? `SMR_ERR_UE : `SMR_ERR_CE_REC);
         end
         else
         begin
            rec = rec | `SMR_ERR_OF;
         end
      end
      return rec;
   endfunction

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   smr_state_t state_ff;
   smr_state_t nxt_state;
   logic wr_go;
   logic wr_ok;
   logic [`SMR_ADDR_W-1:0] wa;
   logic [31:0] rd_word;

   // ----------------------------------------------------------------------
   // bus handshakes
   // ----------------------------------------------------------------------

   // one write and one read in flight; ready drops while held
   assign s_axi_awready = !state_ff.aw_held && !state_ff.bvalid;
   assign s_axi_wready = !state_ff.w_held && !state_ff.bvalid;
   assign s_axi_arready = !state_ff.rvalid;
   assign s_axi_bvalid = state_ff.bvalid;
   assign s_axi_rvalid = state_ff.rvalid;
   assign s_axi_rdata = state_ff.rdata;
   assign s_axi_bresp = `SMR_RESP_OKAY;
   assign s_axi_rresp = `SMR_RESP_OKAY;

   // write takes effect once address and data are both held
   assign wr_go = state_ff.aw_held && state_ff.w_held;
   assign wa = state_ff.awaddr;
   // filtered and unbuilt locations drop the write
   assign wr_ok = wr_go && !is_blocked(wa, state_ff.aw_ns)
      && !is_unimpl(wa);

   // ----------------------------------------------------------------------
   // read multiplexer
   // ----------------------------------------------------------------------

   // unmatched offsets fall through to zero
   always_comb
   begin
      rd_word = `SMR_RESET_WORD;
      if (!is_blocked(s_axi_araddr, s_axi_arprot[1])
         && !is_unimpl(s_axi_araddr))
      begin
         unique case (s_axi_araddr[11:2])
            `SMR_OFS_CR0 >> 2: rd_word = state_ff.cr0;
            `SMR_OFS_CR0_DONE >> 2: rd_word = state_ff.cr0_done;
            `SMR_OFS_IRQ_EN >> 2: rd_word = state_ff.irq_en;
            `SMR_OFS_IRQ_DONE >> 2: rd_word = state_ff.irq_done;
            `SMR_OFS_GBPA >> 2: rd_word = state_ff.gbpa;
            `SMR_OFS_INIT >> 2: rd_word = {31'h0, state_ff.init_busy};
            `SMR_OFS_GERR >> 2: rd_word = state_ff.gerr;
            `SMR_OFS_GERR_ACK >> 2: rd_word = state_ff.gerr_ack;
            `SMR_OFS_STRTAB_LO >> 2: rd_word = state_ff.strtab[31:0];
            `SMR_OFS_STRTAB_HI >> 2: rd_word = state_ff.strtab[63:32];
            `SMR_OFS_ERR_TCU >> 2: rd_word = state_ff.err_rec[0];
            `SMR_OFS_ERR_TBU >> 2: rd_word = state_ff.err_rec[1];
            `SMR_OFS_PMU_CNT_LO >> 2: rd_word = state_ff.pmu_cnt[31:0];
            `SMR_OFS_PMU_CNT_HI >> 2: rd_word = state_ff.pmu_cnt[63:32];
            `SMR_OFS_PMU_CTRL >> 2: rd_word = {31'h0, state_ff.pmu_en};
            default: rd_word = `SMR_RESET_WORD;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      nxt_state = state_ff;

      // capture write address and data in either order
      if (s_axi_awvalid && s_axi_awready)
      begin
         nxt_state.aw_held = 1'b1;
         nxt_state.awaddr = s_axi_awaddr;
         nxt_state.aw_ns = s_axi_awprot[1];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         nxt_state.w_held = 1'b1;
         nxt_state.wdata = s_axi_wdata;
         nxt_state.wstrb = s_axi_wstrb;
      end
      if (wr_go)
      begin
         nxt_state.aw_held = 1'b0;
         nxt_state.w_held = 1'b0;
         nxt_state.bvalid = 1'b1;
      end
      if (state_ff.bvalid && s_axi_bready)
      begin
         nxt_state.bvalid = 1'b0;
      end

      // read answers one cycle after the address is taken
      if (s_axi_arvalid && s_axi_arready)
      begin
         nxt_state.rvalid = 1'b1;
         nxt_state.rdata = rd_word;
      end
      else if (state_ff.rvalid && s_axi_rready)
      begin
         nxt_state.rvalid = 1'b0;
      end

      // update-done registers mirror the value one cycle after it applies
      nxt_state.cr0_done = state_ff.cr0;
      nxt_state.irq_done = state_ff.irq_en;

      // invalidation ends when the caches report done
      if (secure_cache_invalidate_done)
      begin
         nxt_state.init_busy = 1'b0;
      end

      // counter runs while enabled
      if (state_ff.pmu_en && performance_counter_event)
      begin
         nxt_state.pmu_cnt = state_ff.pmu_cnt + 64'h0000_0000_0000_0001;
      end

      // register writes; masks keep reserved bits at zero
      if (wr_ok)
      begin
         unique case (wa[11:2])
            `SMR_OFS_CR0 >> 2:
               nxt_state.cr0 = strb_merge(state_ff.cr0, state_ff.wdata,
                  state_ff.wstrb) & `SMR_MASK_CR0;
            `SMR_OFS_IRQ_EN >> 2:
               nxt_state.irq_en = strb_merge(state_ff.irq_en,
                  state_ff.wdata, state_ff.wstrb) & `SMR_MASK_IRQ_EN;
            `SMR_OFS_GBPA >> 2:
               nxt_state.gbpa = strb_merge(state_ff.gbpa, state_ff.wdata,
                  state_ff.wstrb) & `SMR_MASK_GBPA;
            `SMR_OFS_INIT >> 2:
               if (state_ff.wstrb[0] && state_ff.wdata[0])
               begin
                  nxt_state.init_busy = 1'b1;
               end
            `SMR_OFS_GERR_ACK >> 2:
               nxt_state.gerr_ack = strb_merge(state_ff.gerr_ack,
                  state_ff.wdata, state_ff.wstrb) & `SMR_MASK_GERR;
            `SMR_OFS_STRTAB_LO >> 2:
               nxt_state.strtab[31:0] = strb_merge(state_ff.strtab[31:0],
                  state_ff.wdata, state_ff.wstrb);
            `SMR_OFS_STRTAB_HI >> 2:
               nxt_state.strtab[63:32] = strb_merge(
                  state_ff.strtab[63:32], state_ff.wdata,
                  state_ff.wstrb);
            `SMR_OFS_PMU_CNT_LO >> 2:
               nxt_state.pmu_cnt[31:0] = strb_merge(
                  state_ff.pmu_cnt[31:0], state_ff.wdata,
                  state_ff.wstrb);
            `SMR_OFS_PMU_CNT_HI >> 2:
               nxt_state.pmu_cnt[63:32] = strb_merge(
                  state_ff.pmu_cnt[63:32], state_ff.wdata,
                  state_ff.wstrb);
            `SMR_OFS_PMU_CTRL >> 2:
               if (state_ff.wstrb[0])
               begin
                  nxt_state.pmu_en = state_ff.wdata[0];
               end
            default:
               nxt_state.cr0 = state_ff.cr0;
         endcase
      end

      // an error toggles its status bit only while acknowledged
      for (int i = 0; i < 2; i++)
      begin
         if (secure_global_error_event[i]
            && (state_ff.gerr[i] == nxt_state.gerr_ack[i]))
         begin
            nxt_state.gerr[i] = ~state_ff.gerr[i];
         end
      end

      // error records of the control unit and the buffer unit
      for (int u = 0; u < 2; u++)
      begin
         nxt_state.err_rec[u] = err_update(state_ff.err_rec[u],
            wr_ok && (wa[2] == u[0])
               && (wa[11:3] == `SMR_OFS_ERR_TCU >> 3),
            state_ff.wdata, error_record_event[u],
            error_record_uncorrected[u]);
      end
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------------
   // control outputs to the translation logic
   // ----------------------------------------------------------------------
   assign secure_global_control0 = state_ff.cr0;
   assign secure_interrupt_enables = state_ff.irq_en;
   assign secure_global_bypass_attributes = state_ff.gbpa;
   assign secure_stream_table_base = state_ff.strtab;
   assign secure_cache_invalidate_req = state_ff.init_busy;

endmodule
